// >>> can_bit_timing_defs.svh
`ifndef CAN_BIT_TIMING_DEFS_SVH
`define CAN_BIT_TIMING_DEFS_SVH

// word offsets on the register bus
`define OFS_TIMING_ONE     2'h0
`define OFS_TIMING_TWO     2'h1
`define OFS_CONTROL        2'h2
`define OFS_FLAGS          2'h3

// timing_config_one fields
`define PRESCALER_FIELD    5:0
`define JUMP_WIDTH_FIELD   7:6
// timing_config_two fields
`define PROP_SEGMENT_FIELD 2:0
`define PHASE_ONE_FIELD    5:3
`define TRIPLE_SAMPLE_BIT  6
`define PHASE_TWO_AUTO_BIT 7
`define PHASE_TWO_FIELD    10:8
// control and flag bits
`define CLOCK_SELECT_BIT   0
`define BUS_OFF_BIT        13

// reset values
`define TIMING_ONE_RESET   16'h0000
`define TIMING_TWO_RESET   16'h0000
`define CONTROL_RESET      16'h0000

// timing
`define CORE_CLK_PERIOD_NS 10
`define MIN_BIT_TIME_NS    1000
`define FCY_DIVIDE         2'h3
`define BUS_OFF_LIMIT      255
`define PROC_TIME_TQ       5'h02
`define SYNC_SEG_TQ        5'h01

`endif

// >>> can_bit_timing_pkg.sv
package can_bit_timing_pkg;
  typedef logic [1:0]  reg_addr_t;
  typedef logic [15:0] reg_data_t;
  typedef logic [4:0]  tq_count_t;
  typedef enum logic [0:0] {
    NODE_IDLE = 1'b0,
    NODE_SEND = 1'b1
  } node_state_t;
endpackage

// >>> can_bus_if.sv
`timescale 1ns/1ps
// wired-and bus: dominant is low, recessive high
interface can_bus_if;
  logic deviceTx;
  logic nodeTx;
  logic busLevel;

  assign busLevel = deviceTx & nodeTx;

  modport device (output deviceTx, input busLevel);
  modport node   (output nodeTx,   input busLevel);
endinterface

// >>> can_node_end.sv
`timescale 1ns/1ps
`include "can_bit_timing_defs.svh"
// far node: sends bits at a fixed, legal nominal timing
module can_node_end #(
  parameter int PRESCALE  = 5,
  parameter int PROP_TQ   = 2,
  parameter int PHASE1_TQ = 4,
  parameter int PHASE2_TQ = 3,
  parameter int JUMP_TQ   = 1
) (
  input  wire logic  core_clk,
  input  wire logic  rst,
  can_bus_if.node    bus,
  input  wire logic  txBit,
  input  wire logic  txValid,
  output logic       txReady
);
  import can_bit_timing_pkg::*;

  localparam int BIT_TQ     = 1 + PROP_TQ + PHASE1_TQ + PHASE2_TQ;
  localparam int BIT_CYCLES = BIT_TQ * 2 * PRESCALE;
  localparam int SAMPLE_TQ  = 1 + PROP_TQ + PHASE1_TQ;

  if (PROP_TQ < 1 || PROP_TQ > 8 || PHASE1_TQ < 1 || PHASE1_TQ > 8 || PHASE2_TQ < 1 || PHASE2_TQ > 8)
    $error("segment lengths must be 1 to 8 quanta");
  if (BIT_TQ < 8 || BIT_TQ > 25)
    $error("nominal bit must be 8 to 25 quanta");
  if (BIT_CYCLES * `CORE_CLK_PERIOD_NS < `MIN_BIT_TIME_NS)
    $error("bit time below one microsecond");
  if (PROP_TQ + PHASE1_TQ < PHASE2_TQ)
    $error("prop plus phase one shorter than phase two");
  if (SAMPLE_TQ * 100 < 60 * BIT_TQ || SAMPLE_TQ * 100 > 70 * BIT_TQ)
    $error("sample point outside 60 to 70 percent");
  if (JUMP_TQ < 1 || JUMP_TQ > 4 || PHASE2_TQ <= JUMP_TQ)
    $error("phase two must exceed jump width");
  if (PRESCALE < 1 || PRESCALE > 64)
    $error("prescale must be 1 to 64");

  node_state_t       state;
  logic        [15:0] cycleCnt;
  logic              lastCycle;

  assign lastCycle = (cycleCnt == 16'(BIT_CYCLES - 1));

  // bit sequencing, back to back when valid stays high
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state    <= NODE_IDLE;
      cycleCnt <= 16'h0000;
      txReady  <= 1'b1;
      bus.nodeTx <= 1'b1;
    end else begin
      case (state)
        NODE_IDLE: begin
          if (txValid && txReady) begin
            state      <= NODE_SEND;
            cycleCnt   <= 16'h0000;
            bus.nodeTx <= txBit;
            txReady    <= (BIT_CYCLES == 1);
          end
        end
        NODE_SEND: begin
          if (lastCycle) begin
            cycleCnt <= 16'h0000;
            if (txValid && txReady) begin
              bus.nodeTx <= txBit;
              txReady    <= 1'b0;
            end else begin
              state      <= NODE_IDLE;
              bus.nodeTx <= 1'b1;
              txReady    <= 1'b1;
            end
          end else begin
            cycleCnt <= cycleCnt + 16'h0001;
            txReady  <= (cycleCnt == 16'(BIT_CYCLES - 2));
          end
        end
        default: begin
          state      <= NODE_IDLE;
          bus.nodeTx <= 1'b1;
          txReady    <= 1'b1;
        end
      endcase
    end
  end
endmodule // can_node_end

// >>> can_bit_timing_unit.sv
`timescale 1ns/1ps
`include "can_bit_timing_defs.svh"
module can_bit_timing_unit #(
  parameter int ERR_W = 9
) (
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  can_bus_if.device                         bus,
  input  wire can_bit_timing_pkg::reg_addr_t address,
  input  wire logic                         read,
  input  wire logic                         write,
  input  wire can_bit_timing_pkg::reg_data_t writedata,
  output can_bit_timing_pkg::reg_data_t     readdata,
  output logic                              waitrequest,
  input  wire logic [ERR_W-1:0]             txErrorCount,
  input  wire logic                         busIdle,
  input  wire logic                         txLevel,
  output logic                              rxBit,
  output logic                              rxValid,
  output logic                              bitStart,
  output logic                              busOff
);
  import can_bit_timing_pkg::*;

  if (ERR_W < 9)
    $error("error counter must hold values above 255");

  reg_data_t timingOne;
  reg_data_t timingTwo;
  reg_data_t control;

  logic      [1:0] fcyCnt;
  logic            canClkEn;
  logic      [5:0] brpCnt;
  logic            halfTick;
  logic            halfPhase;
  logic            tqTick;
  logic      [1:0] history;
  logic            prevTqLevel;
  logic            edgeSeen;

  tq_count_t pos;
  tq_count_t ext;
  tq_count_t cut;
  logic      hardDone;
  tq_count_t propLen;
  tq_count_t ph1Len;
  tq_count_t ph2Prog;
  tq_count_t ph2Len;
  tq_count_t sjwLen;
  tq_count_t seg1Cur;
  tq_count_t bitEndCur;
  tq_count_t seg1Next;
  tq_count_t bitEndNext;
  tq_count_t next_ext;
  tq_count_t next_cut;
  logic      hardSync;
  logic      restart;
  logic      majority;

  // register bus: one wait cycle, then the answer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata    <= 16'h0000;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
      case (address)
        `OFS_TIMING_ONE: readdata <= timingOne;
        `OFS_TIMING_TWO: readdata <= timingTwo;
        `OFS_CONTROL:    readdata <= control;
        `OFS_FLAGS:      readdata <= 16'(busOff) << `BUS_OFF_BIT;
        default:         readdata <= 16'h0000;
      endcase
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // writes land at the edge that sees waitrequest low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      timingOne <= `TIMING_ONE_RESET;
      timingTwo <= `TIMING_TWO_RESET;
      control   <= `CONTROL_RESET;
    end else if (write && !waitrequest) begin
      case (address)
        `OFS_TIMING_ONE: timingOne <= {8'h00, writedata[7:0]};
        `OFS_TIMING_TWO: timingTwo <= {5'h00, writedata[10:0]};
        `OFS_CONTROL:    control   <= {15'h0000, writedata[`CLOCK_SELECT_BIT]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      busOff <= 1'b0;
    end else begin
      busOff <= (txErrorCount > ERR_W'(`BUS_OFF_LIMIT));
    end
  end

  // core clock is the 4x clock
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fcyCnt <= 2'h0;
    end else begin
      fcyCnt <= (fcyCnt == `FCY_DIVIDE) ? 2'h0 : fcyCnt + 2'h1;
    end
  end
  assign canClkEn = control[`CLOCK_SELECT_BIT] ? (fcyCnt == `FCY_DIVIDE) : 1'b1;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      brpCnt    <= 6'h00;
      halfTick  <= 1'b0;
      halfPhase <= 1'b0;
    end else begin
      halfTick <= 1'b0;
      if (canClkEn) begin
        if (brpCnt == timingOne[`PRESCALER_FIELD]) begin
          brpCnt    <= 6'h00;
          halfTick  <= 1'b1;
          halfPhase <= ~halfPhase;
        end else begin
          brpCnt <= brpCnt + 6'h01;
        end
      end
    end
  end
  assign tqTick = halfTick & halfPhase;

  assign propLen = {2'h0, timingTwo[`PROP_SEGMENT_FIELD]} + 5'h01;
  assign ph1Len  = {2'h0, timingTwo[`PHASE_ONE_FIELD]} + 5'h01;
  assign ph2Prog = {2'h0, timingTwo[`PHASE_TWO_FIELD]} + 5'h01;
  assign sjwLen  = {3'h0, timingOne[`JUMP_WIDTH_FIELD]} + 5'h01;

  always_comb begin
    if (timingTwo[`PHASE_TWO_AUTO_BIT]) begin
      ph2Len = (ph1Len > `PROC_TIME_TQ) ? ph1Len : `PROC_TIME_TQ;
    end else begin
      ph2Len = ph2Prog;
    end
  end

  // sync, prop, phase one, phase two back to back
  assign seg1Cur    = `SYNC_SEG_TQ + propLen + ph1Len + ext;
  assign bitEndCur  = seg1Cur + ph2Len - cut;
  assign seg1Next   = `SYNC_SEG_TQ + propLen + ph1Len + next_ext;
  assign bitEndNext = seg1Next + ph2Len - next_cut;

  // edges judged at quantum granularity
  assign edgeSeen = tqTick & prevTqLevel & ~bus.busLevel;

  always_comb begin
    next_ext = ext;
    next_cut = cut;
    hardSync = 1'b0;
    restart  = 1'b0;
    if (edgeSeen && busIdle) begin
      hardSync = 1'b1;
    end else if (edgeSeen && !hardDone && pos != 5'h00) begin
      // late edge stretches, early edge shortens
      if (pos < seg1Cur) begin
        next_ext = (pos > sjwLen) ? sjwLen : pos;
      end else if ((bitEndCur - pos) <= sjwLen) begin
        restart = 1'b1;
      end else begin
        next_cut = sjwLen;
      end
    end
  end

  // bit sequencer, advances once per quantum
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pos         <= 5'h00;
      ext         <= 5'h00;
      cut         <= 5'h00;
      hardDone    <= 1'b0;
      bitStart    <= 1'b0;
      prevTqLevel <= 1'b1;
    end else begin
      bitStart <= 1'b0;
      if (tqTick) begin
        prevTqLevel <= bus.busLevel;
        if (hardSync || restart) begin
          // edge quantum becomes the sync segment
          pos      <= `SYNC_SEG_TQ;
          ext      <= 5'h00;
          cut      <= 5'h00;
          hardDone <= hardSync;
          bitStart <= 1'b1;
        end else if (pos == bitEndNext - 5'h01) begin
          pos      <= 5'h00;
          ext      <= 5'h00;
          cut      <= 5'h00;
          hardDone <= 1'b0;
          bitStart <= 1'b1;
        end else begin
          pos <= pos + 5'h01;
          ext <= next_ext;
          cut <= next_cut;
        end
      end
    end
  end

  // bus history at each half quantum
  always_ff @(posedge core_clk) begin
    if (rst) begin
      history <= 2'h3;
    end else if (halfTick) begin
      history <= {history[0], bus.busLevel};
    end
  end

  assign majority = (bus.busLevel & history[0]) | (bus.busLevel & history[1]) | (history[0] & history[1]);

  // sample at end of phase one
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rxBit   <= 1'b1;
      rxValid <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      if (tqTick && !hardSync && !restart && pos == seg1Next - 5'h01) begin
        rxBit   <= timingTwo[`TRIPLE_SAMPLE_BIT] ? majority : bus.busLevel;
        rxValid <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus.deviceTx <= 1'b1;
    end else begin
      bus.deviceTx <= txLevel;
    end
  end
endmodule // can_bit_timing_unit

// >>> can_bit_timing_props.sv
`timescale 1ns/1ps
module can_bit_timing_props #(
  parameter int ERR_W = 9
) (
  input wire logic             core_clk,
  input wire logic             rst,
  input wire logic             busLevel,
  input wire logic             busIdle,
  input wire logic             read,
  input wire logic             write,
  input wire logic             waitrequest,
  input wire logic [ERR_W-1:0] txErrorCount,
  input wire logic             rxBit,
  input wire logic             rxValid,
  input wire logic             bitStart,
  input wire logic             busOff
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  AST_BUS_OFF_SET: assert property (txErrorCount > 255 |=> busOff)
    else $error("busOff missing with count above limit");
  AST_BUS_OFF_CLEAR: assert property (txErrorCount <= 255 |=> !busOff)
    else $error("busOff set with count at or below limit");
  AST_REG_ANSWER: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("register access not answered in one cycle");
  AST_SAMPLE_PULSE: assert property (rxValid |=> !rxValid)
    else $error("sample pulse longer than one cycle");
  AST_BIT_HELD: assert property (!rxValid |-> $stable(rxBit))
    else $error("bit value changed outside sample point");
  AST_SYNC_PULSE: assert property (bitStart |=> !bitStart)
    else $error("bit start pulse longer than one cycle");
  // a sync restart starts counting at the second quantum, so only two quanta are certain
  AST_SAMPLE_AFTER_SYNC: assert property (bitStart |=> !rxValid [*3])
    else $error("sample point inside sync segment");
  AST_HARD_SYNC: assert property (busIdle && $fell(busLevel) |-> ##[0:40] bitStart)
    else $error("no restart after idle falling edge");

  cover property (busOff);
  cover property (busIdle && $fell(busLevel));
  cover property (rxValid && !rxBit);
endmodule // can_bit_timing_props

// >>> can_bit_timing_unit_tb_top.sv
`timescale 1ns/1ps
`include "can_bit_timing_defs.svh"
module can_bit_timing_unit_tb_top;
  import can_bit_timing_pkg::*;
  logic       core_clk;
  logic       rst;
  reg_addr_t  address;
  logic       read;
  logic       write;
  reg_data_t  writedata;
  reg_data_t  readdata;
  logic       waitrequest;
  logic [8:0] txErrorCount;
  logic       busIdle;
  logic       txLevel;
  logic       rxBit;
  logic       rxValid;
  logic       bitStart;
  logic       busOff;
  logic       txBit;
  logic       txValid;
  logic       txReady;
  int         num_errors = 0;
  int         tests_run = 0;
  int         cyc = 0;
  logic       rxq[$];
  reg_data_t  rd;
  reg_data_t  d;
  reg_data_t  masks[3] = '{16'h00ff, 16'h07ff, 16'h0001};
  reg_data_t  resets[4] = '{`TIMING_ONE_RESET, `TIMING_TWO_RESET, `CONTROL_RESET, 16'h0000};
  logic [8:0] errv[5] = '{9'd255, 9'd256, 9'd511, 9'd0, 9'd300};

  can_bus_if busIf();
  can_bit_timing_unit can_bit_timing_unit_i(.core_clk(core_clk), .rst(rst), .bus(busIf), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .txErrorCount(txErrorCount), .busIdle(busIdle), .txLevel(txLevel), .rxBit(rxBit), .rxValid(rxValid),
    .bitStart(bitStart), .busOff(busOff));
  can_node_end can_node_end_i(.core_clk(core_clk), .rst(rst), .bus(busIf), .txBit(txBit), .txValid(txValid),
    .txReady(txReady));
  can_bit_timing_props #(.ERR_W(9)) can_bit_timing_props_i(.core_clk(core_clk), .rst(rst),
    .busLevel(busIf.busLevel), .busIdle(busIdle), .read(read), .write(write), .waitrequest(waitrequest),
    .txErrorCount(txErrorCount), .rxBit(rxBit), .rxValid(rxValid), .bitStart(bitStart), .busOff(busOff));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (rxValid === 1'b1) rxq.push_back(rxBit);
  end

  task close_out;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one Avalon access; read data taken at the edge that ends the wait
  task automatic reg_acc(input logic wr, input reg_addr_t a, input reg_data_t v);
    int n = 0;
    @(posedge core_clk);
    address <= a;
    writedata <= v;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge core_clk);
      n++;
      rd = readdata;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) num_errors++;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic wait_sig(input bit which, output int t);
    int n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while ((which ? rxValid : bitStart) !== 1'b1 && n < 20000);
    if (n >= 20000) num_errors++;
    t = cyc;
  endtask

  // core cycles per quantum for a prescaler field and clock select
  function automatic int tq_cycles(input int p, input int s);
    return 2 * (p + 1) * (s ? 4 : 1);
  endfunction

  // quanta per nominal bit from the raw segment fields
  function automatic int bit_quanta(input int pr, input int p1, input int p2, input int au);
    return pr + p1 + 3 + (au ? ((p1 + 1 > 2) ? p1 + 1 : 2) : p2 + 1);
  endfunction

  task automatic timing(input int p, s, pr, p1, p2, au);
    int tq, bq, t0, t1, t2;
    tq = tq_cycles(p, s);
    bq = bit_quanta(pr, p1, p2, au);
    reg_acc(1'b1, `OFS_TIMING_ONE, 16'(p));
    reg_acc(1'b1, `OFS_CONTROL, 16'(s));
    reg_acc(1'b1, `OFS_TIMING_TWO, 16'((p2 << 8) | (au << 7) | (p1 << 3) | pr));
    // first start may still belong to the old setting
    wait_sig(1'b0, t0);
    wait_sig(1'b0, t0);
    wait_sig(1'b1, t1);
    wait_sig(1'b0, t2);
    check(16'(t1 - t0), 16'((pr + p1 + 3) * tq));
    check(16'(t2 - t0), 16'(bq * tq));
    $display("timing test done prescaler %0d select %0d", p, s);
  endtask

  task automatic node_send(input logic b);
    int n = 0;
    @(posedge core_clk);
    txBit <= b;
    txValid <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (txReady !== 1'b1 && n < 500);
    if (n >= 500) num_errors++;
  endtask

  // valid held between bits so the node sends them back to back
  task automatic frame(input reg_data_t c1, input reg_data_t c2, input bit alt);
    logic sent[$];
    int k = 0;
    reg_acc(1'b1, `OFS_TIMING_ONE, c1);
    reg_acc(1'b1, `OFS_CONTROL, 16'h0000);
    reg_acc(1'b1, `OFS_TIMING_TWO, c2);
    rxq.delete();
    busIdle <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      sent.push_back(i == 0 ? 1'b0 : (alt ? i[0] : 1'($urandom)));
      node_send(sent[i]);
      if (i == 1) busIdle <= 1'b0;
    end
    @(posedge core_clk);
    txValid <= 1'b0;
    repeat (200) @(posedge core_clk);
    while (k < rxq.size() && rxq[k] !== 1'b0) k++;
    for (int i = 0; i < 13; i++) check(16'(rxq[k + i]), 16'(sent[i]));
    $display("frame test done config %h", c2);
  endtask

  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    writedata = '0;
    txErrorCount = '0;
    busIdle = 1'b0;
    txLevel = 1'b1;
    txBit = 1'b1;
    txValid = 1'b0;
    void'($urandom(38));
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    check(16'(rxBit), 16'h0001);
    for (int a = 0; a < 4; a++) begin
      reg_acc(1'b0, 2'(a), 16'h0000);
      check(rd, resets[a]);
    end
    for (int j = 0; j < 2; j++) begin
      for (int a = 0; a < 3; a++) begin
        d = j ? 16'($urandom) : 16'hffff;
        reg_acc(1'b1, 2'(a), d);
        reg_acc(1'b0, 2'(a), 16'h0000);
        check(rd, d & masks[a]);
      end
    end
    reg_acc(1'b1, `OFS_FLAGS, 16'hffff);
    reg_acc(1'b0, `OFS_FLAGS, 16'h0000);
    check(rd, 16'h0000);
    $display("register test done");
    errv[4] = 9'($urandom);
    foreach (errv[i]) begin
      txErrorCount <= errv[i];
      repeat (3) @(posedge core_clk);
      check(16'(busOff), 16'(errv[i] > 255));
      reg_acc(1'b0, `OFS_FLAGS, 16'h0000);
      check(rd, 16'(errv[i] > 255) << 13);
    end
    txErrorCount <= '0;
    txLevel <= 1'b0;
    repeat (2) @(posedge core_clk);
    check(16'(busIf.busLevel), 16'h0000);
    txLevel <= 1'b1;
    $display("bus off test done");
    timing(0, 0, 0, 0, 0, 0);
    timing(0, 0, 7, 7, 7, 0);
    timing(1, 1, 2, 5, 0, 1);
    timing(0, 1, 1, 0, 4, 1);
    timing(63, 0, 1, 2, 1, 0);
    repeat (3) timing($urandom % 4, $urandom % 2, $urandom % 8, $urandom % 8, $urandom % 8, $urandom % 2);
    frame(16'h0004, 16'h0219, 1'b0);
    frame(16'h0004, 16'h0259, 1'b0);
    // device one quantum short; falling edges every second bit, so a two-quantum jump is needed
    frame(16'h0044, 16'h0218, 1'b1);
    // device one quantum long; early edges in phase two restart the bit
    frame(16'h0044, 16'h0319, 1'b1);
    close_out();
  end

  initial begin
    #(80000 * 10);
    num_errors++;
    close_out();
  end
endmodule // can_bit_timing_unit_tb_top
